// ===== core/tmr_pkg.sv
package tmr_pkg;
  // Register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CMP_OFS = 8'h08;
  localparam logic [7:0] OUTCTL_OFS = 8'h0C;
  localparam logic [7:0] PFS_OFS = 8'h10;
  localparam logic [7:0] SHORT_OFS = 8'h14;
  localparam logic [7:0] DIS_OFS = 8'h18;
  localparam logic [7:0] STAT_OFS = 8'h1C;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [3:0] OUTCTL_RST = 4'h0;
  localparam logic [3:0] PFS_RST = 4'h0;
  localparam logic [3:0] SHORT_RST = 4'h0;
  localparam logic [11:0] DIS_RST = 12'h000;
  // Count source field of the mode register
  localparam int SRC_LSB = 0;
  localparam logic [1:0] SRC_EVENT = 2'h0;
  localparam logic [1:0] SRC_SINGLE = 2'h1;
  localparam logic [1:0] SRC_BOTH = 2'h2;
  localparam logic [1:0] SRC_PHASE = 2'h3;
  // Disable register fields
  localparam int DIS_HZ_TMR = 0;
  localparam int DIS_PS_TMR = 2;
  localparam int DIS_HZ_POE = 4;
  localparam int DIS_HZ_GRP = 6;
  localparam int DIS_PORT = 8;
  // Status register fields
  localparam int STAT_PINS = 0;
  localparam int STAT_SHORT = 4;
  localparam int STAT_STOP = 5;
  // Pins: 0,1 timer outputs, 2,3 PWM outputs
  localparam int NPIN = 4;
  typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_ACK = 2'b01} apb_state_t;
endpackage

// ===== core/cnt_if.sv
`timescale 1ns/100ps
interface cnt_if #(parameter int CW = 16);
  logic ce;
  logic a;
  logic b;
  logic evt;
  logic clr;
  logic [1:0] src;
  logic [CW-1:0] count;
  modport ctrl(output ce, a, b, evt, clr, src, input count);
  modport cnt(input ce, a, b, evt, clr, src, output count);
endinterface

// ===== core/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;

  initial begin
    if (W < 1) $error("pin_sync: W must be at least 1");
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else if (i_ce) begin
      ff1_r <= i_d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // Bit changes only once second and third stages agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_q <= '0;
    end else if (i_ce) begin
      o_q <= (ff3_r & ~(ff2_r ^ ff3_r)) | (o_q & (ff2_r ^ ff3_r));
    end
  end
endmodule

// ===== core/edge_counter.sv
`timescale 1ns/100ps
module edge_counter #(
  parameter int CW = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  cnt_if.cnt port
);
  logic pa_r;
  logic pb_r;
  logic up;
  logic dn;

  initial begin
    if (CW < 2 || CW > 32) $error("edge_counter: CW out of range");
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pa_r <= 1'b0;
      pb_r <= 1'b0;
    end else if (port.ce) begin
      pa_r <= port.a;
      pb_r <= port.b;
    end
  end

  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    case (port.src)
      tmr_pkg::SRC_EVENT: up = port.evt;
      tmr_pkg::SRC_SINGLE: up = port.a & ~pa_r;
      tmr_pkg::SRC_BOTH: up = port.a ^ pa_r;
      tmr_pkg::SRC_PHASE: begin
        up = (port.a ^ pb_r) & ~(port.b ^ pa_r);
        dn = (port.b ^ pa_r) & ~(port.a ^ pb_r);
      end
      default: up = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      port.count <= '0;
    end else if (port.ce) begin
      if (port.clr) begin
        port.count <= '0;
      end else if (up) begin
        port.count <= port.count + 1'b1;
      end else if (dn) begin
        port.count <= port.count - 1'b1;
      end
    end
  end
endmodule

// ===== core/timer_qualify_top.sv
// Function
// - Timer output inversion flips pin polarity
// - PWM output inversion flips pin polarity
// - High-impedance pins read zero
// - Port-switched pins read normally
`timescale 1ns/100ps
module timer_qualify_top #(
  parameter int CW = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_event,
  input wire logic i_stop_req,
  input wire logic [3:0] i_pin_in,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  output logic o_short_det
);
  localparam int NP = tmr_pkg::NPIN;

  initial begin
    if (CW < 2 || CW > 16) $error("timer_qualify_top: CW must be 2..16");
  end

  ////////////////////////////////////////////////////////////////////////
  // Input qualification
  logic [1:0] phase_q;
  logic stop_q;
  logic [NP-1:0] pin_q;

  pin_sync #(.W(2)) u_phase_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d({i_phase_b, i_phase_a}),
    .o_q(phase_q)
  );

  pin_sync #(.W(NP + 1)) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d({i_stop_req, i_pin_in}),
    .o_q({stop_q, pin_q})
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] mode_r;
  logic [31:0] cmp_r;
  logic [3:0] outctl_r;
  logic [3:0] pfs_r;
  logic [3:0] short_lvl_r;
  logic [11:0] dis_r;
  logic short_r;
  logic stop_r;
  logic clr_r;
  tmr_pkg::apb_state_t apb_r;
  tmr_pkg::apb_state_t apb_nxt;
  logic wr_en;
  logic hit;
  logic [31:0] rd_nxt;
  logic [CW-1:0] count;
  logic [NP-1:0] rb_r;

  always_comb begin
    apb_nxt = apb_r;
    case (apb_r)
      tmr_pkg::APB_IDLE: if (i_psel && i_penable) apb_nxt = tmr_pkg::APB_ACK;
      tmr_pkg::APB_ACK: apb_nxt = tmr_pkg::APB_IDLE;
      default: apb_nxt = tmr_pkg::APB_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      apb_r <= tmr_pkg::APB_IDLE;
    end else if (i_ce) begin
      apb_r <= apb_nxt;
    end
  end

  // Write lands at the edge that samples pready high
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;

  // Per-register write strobes
  logic wr_mode;
  logic wr_cmp;
  logic wr_outctl;
  logic wr_pfs;
  logic wr_short;
  logic wr_dis;
  logic wr_count;
  logic wr_stat;
  assign wr_mode = wr_en && (i_paddr == tmr_pkg::MODE_OFS);
  assign wr_cmp = wr_en && (i_paddr == tmr_pkg::CMP_OFS);
  assign wr_outctl = wr_en && (i_paddr == tmr_pkg::OUTCTL_OFS);
  assign wr_pfs = wr_en && (i_paddr == tmr_pkg::PFS_OFS);
  assign wr_short = wr_en && (i_paddr == tmr_pkg::SHORT_OFS);
  assign wr_dis = wr_en && (i_paddr == tmr_pkg::DIS_OFS);
  assign wr_count = wr_en && (i_paddr == tmr_pkg::COUNT_OFS);
  assign wr_stat = wr_en && (i_paddr == tmr_pkg::STAT_OFS);

  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (i_paddr)
      tmr_pkg::MODE_OFS: rd_nxt[7:0] = mode_r;
      tmr_pkg::COUNT_OFS: rd_nxt[CW-1:0] = count;
      tmr_pkg::CMP_OFS: rd_nxt = cmp_r;
      tmr_pkg::OUTCTL_OFS: rd_nxt[3:0] = outctl_r;
      tmr_pkg::PFS_OFS: rd_nxt[3:0] = pfs_r;
      tmr_pkg::SHORT_OFS: rd_nxt[3:0] = short_lvl_r;
      tmr_pkg::DIS_OFS: rd_nxt[11:0] = dis_r;
      tmr_pkg::STAT_OFS: begin
        rd_nxt[tmr_pkg::STAT_PINS +: NP] = rb_r;
        rd_nxt[tmr_pkg::STAT_SHORT] = short_r;
        rd_nxt[tmr_pkg::STAT_STOP] = stop_r;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_pready <= (apb_nxt == tmr_pkg::APB_ACK);
      o_pslverr <= (apb_nxt == tmr_pkg::APB_ACK) && !hit;
      o_prdata <= (apb_nxt == tmr_pkg::APB_ACK && !i_pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= tmr_pkg::MODE_RST;
    end else if (i_ce && wr_mode) begin
      mode_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_r <= tmr_pkg::CMP_RST;
    end else if (i_ce && wr_cmp) begin
      cmp_r <= i_pwdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      outctl_r <= tmr_pkg::OUTCTL_RST;
    end else if (i_ce && wr_outctl) begin
      outctl_r <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pfs_r <= tmr_pkg::PFS_RST;
    end else if (i_ce && wr_pfs) begin
      pfs_r <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      short_lvl_r <= tmr_pkg::SHORT_RST;
    end else if (i_ce && wr_short) begin
      short_lvl_r <= i_pwdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dis_r <= tmr_pkg::DIS_RST;
    end else if (i_ce && wr_dis) begin
      dis_r <= i_pwdata[11:0];
    end
  end

  // Count write clears the counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clr_r <= 1'b0;
    end else if (i_ce) begin
      clr_r <= wr_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter
  cnt_if #(.CW(CW)) cbus ();
  logic evt_ok;

  // Event action only with mode register zero
  assign evt_ok = i_event && (mode_r == tmr_pkg::MODE_RST);

  assign cbus.ce = i_ce;
  assign cbus.a = phase_q[0];
  assign cbus.b = phase_q[1];
  assign cbus.evt = evt_ok;
  assign cbus.clr = clr_r;
  assign cbus.src = mode_r[tmr_pkg::SRC_LSB +: 2];
  assign count = cbus.count;

  edge_counter #(.CW(CW)) u_counter (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .port(cbus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output levels and polarity
  logic [NP-1:0] active;
  logic [NP-1:0] lvl;
  logic [NP-1:0] pin_lvl;

  assign active[0] = count < cmp_r[CW-1:0];
  assign active[1] = ~active[0];
  assign active[2] = count < cmp_r[16 +: CW];
  assign active[3] = ~active[2];
  assign lvl = ~(active ^ outctl_r);

  // Timer and PWM pins inverted from control level
  assign pin_lvl = lvl ^ pfs_r;

  ////////////////////////////////////////////////////////////////////////
  // Output stop
  logic [NP-1:0] hz_sel;
  logic [NP-1:0] ps_sel;
  logic [NP-1:0] hz;
  logic [NP-1:0] ps;
  logic stop_clr;

  // Both PWM disable sources simply merge
  assign hz_sel = {dis_r[tmr_pkg::DIS_HZ_POE +: 2] | dis_r[tmr_pkg::DIS_HZ_GRP +: 2],
                   dis_r[tmr_pkg::DIS_HZ_TMR +: 2]};
  assign ps_sel = {2'b00, dis_r[tmr_pkg::DIS_PS_TMR +: 2]};
  assign hz = stop_r ? hz_sel : '0;
  assign ps = stop_r ? (ps_sel & ~hz_sel) : '0;
  assign stop_clr = wr_stat && i_pwdata[tmr_pkg::STAT_STOP];

  // Request wins over software clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stop_r <= 1'b0;
    end else if (i_ce) begin
      stop_r <= stop_q || (stop_r && !stop_clr);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
    end else if (i_ce) begin
      o_pin_oe <= ~hz;
      o_pin_out <= ~hz & ((ps & dis_r[tmr_pkg::DIS_PORT +: NP]) | (~ps & pin_lvl));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rb_r <= '0;
    end else if (i_ce) begin
      rb_r <= pin_q & o_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Short detection on driven pin levels
  logic short_now;
  logic short_clr;

  assign short_now = (o_pin_oe[0] && o_pin_oe[1] &&
                      o_pin_out[1:0] == short_lvl_r[1:0]) ||
                     (o_pin_oe[2] && o_pin_oe[3] &&
                      o_pin_out[3:2] == short_lvl_r[3:2]);
  assign short_clr = wr_stat && i_pwdata[tmr_pkg::STAT_SHORT];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      short_r <= 1'b0;
      o_short_det <= 1'b0;
    end else if (i_ce) begin
      short_r <= short_now || (short_r && !short_clr);
      o_short_det <= short_now || (short_r && !short_clr);
    end
  end
endmodule

// ===== sim/pulse_src.sv
`timescale 1ns/100ps
module pulse_src #(
  parameter int HOLD = 3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_step,
  input wire logic i_phase,
  output logic o_a,
  output logic o_b
);
  int t;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      t <= 0;
    end else if (t != 0 || i_step) begin
      t <= (t == 4 * HOLD) ? 0 : t + 1;
    end
  end
  assign o_a = (t >= 1) && (t <= (i_phase ? 2 : 1) * HOLD);
  assign o_b = i_phase && (t > HOLD) && (t <= 3 * HOLD);
endmodule

// ===== sim/timer_qualify_sva.sv
`timescale 1ns/100ps
module timer_qualify_sva #(
  parameter int CW = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_stop_req,
  input wire logic [3:0] o_pin_out,
  input wire logic [3:0] o_pin_oe
);
  logic [11:0] dis_r;
  logic [3:0] scnt_r;
  logic [3:0] hz;
  logic [1:0] ps;
  assign hz = {dis_r[5:4] | dis_r[7:6], dis_r[1:0]};
  assign ps = dis_r[3:2] & ~dis_r[1:0];
  ////////////////////////////////////////
  // Shadow of the disable register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dis_r <= 12'h000;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == tmr_pkg::DIS_OFS) begin
      dis_r <= i_pwdata[11:0];
    end
  end
  // Cycles of stop request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scnt_r <= 4'h0;
    end else if (!i_stop_req) begin
      scnt_r <= 4'h0;
    end else if (scnt_r != 4'hF) begin
      scnt_r <= scnt_r + 4'h1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence access_start;
    i_psel && i_penable && !$past(i_penable);
  endsequence
  sequence stop_held;
    scnt_r == 4'hF && $past(dis_r, 3) == dis_r;
  endsequence
  sequence stat_read;
    o_pready && !i_pwrite && i_paddr == tmr_pkg::STAT_OFS;
  endsequence
  apb_wait_a: assert property (access_start |-> !o_pready ##1 o_pready)
    else $error("no answer after one wait");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("bad error answer");
  hz_pins_a: assert property (stop_held |-> (o_pin_oe & hz) == 4'h0)
    else $error("pin not released");
  hz_read_a: assert property (stop_held ##0 stat_read |-> (o_prdata[3:0] & hz) == 4'h0)
    else $error("released pin read back");
  port_pins_a: assert property (stop_held |->
      (o_pin_oe[1:0] & ps) == ps && (o_pin_out[1:0] & ps) == (dis_r[9:8] & ps))
    else $error("port switched pin wrong");
endmodule
bind timer_qualify_top timer_qualify_sva #(.CW(CW)) chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_stop_req(i_stop_req), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

// ===== sim/timer_clock_qualify_output_polarity_bench.sv
`timescale 1ns/100ps
module timer_clock_qualify_output_polarity_bench;
  logic clk = 0;
  logic rstn = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic ev = 0;
  logic stop = 0;
  logic step = 0;
  logic ce = 1;
  logic phase = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'h9425553F;
  logic [3:0] pin_in = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, a, b, sdet;
  logic [3:0] pout, port_output_disable_unit, ex;
  logic [65:0] q[$];
  logic [65:0] e;
  int fails = 0;
  int check_count = 0;
  int n;
  always #25 clk = ~clk;
  pulse_src #(.HOLD(3)) src (.i_clk(clk), .i_rstn(rstn), .i_step(step), .i_phase(phase),
    .o_a(a), .o_b(b));
  timer_qualify_top #(.CW(16)) dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_phase_a(a), .i_phase_b(b), .i_event(ev),
    .i_stop_req(stop), .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(port_output_disable_unit), .o_short_det(sdet));
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_rd(input logic [32:0] got, input logic [65:0] x);
    check_count++;
    if ((got & x[32:0]) !== (x[65:33] & x[32:0])) begin
      fails++;
      $display("Error %0t read %h want %h", $time, got, x[65:33]);
    end
  endtask
  task automatic cmp_pin(input logic [8:0] x, input logic [8:0] m);
    check_count++;
    if (({sdet, port_output_disable_unit, pout} & m) !== (x & m)) begin
      fails++;
      $display("Error %0t pins %h want %h", $time, {sdet, port_output_disable_unit, pout}, x);
    end
  endtask
  // Read answers against the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && pwr === 1'b0) begin
      e = q.size() > 0 ? q.pop_front() : '1;
      cmp_rd({pslverr, prdata}, e);
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      input logic [65:0] x = '0);
    int k;
    if (!w) q.push_back(x);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      fails++;
      close_out;
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic pulse(input int md);
    if (md == 0) ev <= 1'b1;
    else step <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    step <= 1'b0;
    wt(14);
  endtask
  ////////////////////////////////////////
  initial begin
    wt(3);
    rstn <= 1'b1;
    wt(2);
    cmp_pin({1'b0, 4'hF, 4'h5}, 9'h1FF);
    apb(1'b0, tmr_pkg::MODE_OFS, 32'h0, {33'h0, {33{1'b1}}});
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0, {33{1'b1}}});
    $display("reset test done");
    for (int md = 0; md < 4; md++) begin
      seed = xs(seed);
      n = 1 + seed[1:0];
      phase <= (md == 3);
      apb(1'b1, tmr_pkg::MODE_OFS, 32'(md));
      apb(1'b1, tmr_pkg::COUNT_OFS, 32'h0);
      wt(3);
      repeat (n) pulse(md);
      wt(8);
      e = {1'b0, 32'(n * (md == 2 ? 2 : md == 3 ? 4 : 1)), 33'h0FFFF};
      apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0, e);
    end
    phase <= 1'b0;
    apb(1'b1, tmr_pkg::MODE_OFS, 32'h4);
    apb(1'b1, tmr_pkg::COUNT_OFS, 32'h0);
    wt(3);
    repeat (2) pulse(0);
    apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0, {33'h0, 33'h0FFFF});
    apb(1'b1, tmr_pkg::MODE_OFS, 32'h0);
    ce <= 1'b0;
    repeat (2) pulse(0);
    ce <= 1'b1;
    pulse(0);
    apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0, {33'h1, 33'h0FFFF});
    apb(1'b1, tmr_pkg::COUNT_OFS, 32'h0);
    $display("count test done");
    repeat (6) begin
      seed = xs(seed);
      apb(1'b1, tmr_pkg::OUTCTL_OFS, {28'h0, seed[3:0]});
      apb(1'b1, tmr_pkg::PFS_OFS, {28'h0, seed[7:4]});
      apb(1'b1, tmr_pkg::CMP_OFS, {15'h0, seed[8], 15'h0, seed[9]});
      wt(3);
      ex = ~({~seed[8], seed[8], ~seed[9], seed[9]} ^ seed[3:0]) ^ seed[7:4];
      cmp_pin({1'b0, 4'hF, ex}, 9'h0FF);
    end
    apb(1'b1, tmr_pkg::SHORT_OFS, {28'h0, ex});
    wt(3);
    cmp_pin(9'h100, 9'h100);
    apb(1'b1, tmr_pkg::SHORT_OFS, {28'h0, ~ex});
    apb(1'b1, tmr_pkg::STAT_OFS, 32'h10);
    wt(3);
    cmp_pin(9'h000, 9'h100);
    $display("polarity test done");
    seed = xs(seed);
    pin_in <= {1'b1, seed[2], 1'b0, seed[0]};
    apb(1'b1, tmr_pkg::DIS_OFS, 32'h23C);
    stop <= 1'b1;
    wt(20);
    cmp_pin({1'b0, 4'h3, 4'h2}, 9'h0FF);
    apb(1'b0, tmr_pkg::STAT_OFS, 32'h0, {29'h2, pin_in & 4'h3, 33'h2F});
    apb(1'b1, tmr_pkg::DIS_OFS, 32'h33);
    wt(8);
    cmp_pin(9'h000, 9'h0FF);
    apb(1'b0, tmr_pkg::STAT_OFS, 32'h0, {33'h20, 33'h2F});
    stop <= 1'b0;
    wt(8);
    apb(1'b1, tmr_pkg::STAT_OFS, 32'h20);
    wt(8);
    cmp_pin({1'b0, 4'hF, 4'h0}, 9'h0F0);
    apb(1'b0, tmr_pkg::STAT_OFS, 32'h0, {29'h0, pin_in, 33'h2F});
    $display("stop test done");
    close_out;
  end
  initial begin
    #2000000;
    fails++;
    close_out;
  end
endmodule
